/* verilog/ddp_dram_port.sv */
`timescale 1ns/100ps
`include "ddp_defs.svh"

module ddp_dram_port
  import ddp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Access request from the sequencer
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`DDP_MAPS-1:0] req_map_sel,
  input wire logic [`DDP_ROW_W-1:0] req_addr,
  input wire logic [`DDP_DATA_W-1:0] req_wdata,
  // Read answer
  output logic rd_valid_r,
  output logic [`DDP_DATA_W-1:0] rd_data_r,
  // Configuration straps
  output logic [`DDP_DATA_W-1:0] strap_cfg,
  output logic strap_valid,
  // DRAM pins
  output logic [`DDP_ADDR_W-1:0] dram_mux_address,
  output logic row_strobe_maps_low_pair_n,
  output logic row_strobe_maps_high_pair_n,
  output logic col_strobe_maps_low_pair_n,
  output logic col_strobe_maps_high_pair_n,
  output logic write_strobe_map_zero_n,
  output logic write_strobe_map_one_n,
  output logic write_strobe_map_two_n,
  output logic write_strobe_map_three_n,
  output logic out_enable_maps_low_pair_n,
  output logic out_enable_maps_high_pair_n,
  input wire logic [`DDP_DATA_W-1:0] display_mem_data_in,
  output logic [`DDP_DATA_W-1:0] display_mem_data_out,
  output logic display_mem_data_oe_n
);
  ddp_state_e state_r, state_nxt;
  logic [3:0] cnt_r;
  logic wr_r;
  logic [`DDP_MAPS-1:0] map_r;
  logic [`DDP_ROW_W-1:0] addr_r;
  logic [`DDP_DATA_W-1:0] wdata_r;
  logic [`DDP_ADDR_W-1:0] ma_r;
  logic [1:0] ras_n_r, cas_n_r, oe_n_r;
  logic [`DDP_MAPS-1:0] we_n_r;
  logic drive_r;
  logic [`DDP_DATA_W-1:0] rd_s1_r, rd_s2_r, rd_s3_r;

  // Pair select: bit 0 covers maps 1-0, bit 1 covers maps 3-2
  function automatic logic [1:0] pair_of(input logic [`DDP_MAPS-1:0] m);
    pair_of = {m[3] | m[2], m[1] | m[0]};
  endfunction

  wire cnt_done = (cnt_r == 4'h0);
  wire take = (state_r == DDP_IDLE) && req_valid;
  wire [1:0] pair = pair_of(map_r);

  ddp_strap_cap u_strap (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(display_mem_data_in),
    .strap_r(strap_cfg),
    .strap_valid_r(strap_valid)
  );

  assign req_ready = (state_r == DDP_IDLE);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DDP_STRAP: if (strap_valid) state_nxt = DDP_IDLE;
      DDP_IDLE: if (req_valid) state_nxt = DDP_ROW;
      DDP_ROW: if (cnt_done) state_nxt = DDP_COL;
      DDP_COL: state_nxt = DDP_CAS;
      DDP_CAS: if (cnt_done) state_nxt = DDP_PRE;
      DDP_PRE: if (cnt_done) state_nxt = DDP_IDLE;
      default: state_nxt = DDP_STRAP;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= DDP_STRAP;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else if (take) begin
      cnt_r <= `DDP_T_ROW - 4'h1;
    end else if (state_r == DDP_COL) begin
      cnt_r <= `DDP_T_CAS - 4'h1;
    end else if (state_r == DDP_CAS && cnt_done) begin
      cnt_r <= `DDP_T_PRE - 4'h1;
    end else if (!cnt_done) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_r <= 1'b0;
      map_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
    end else if (take) begin
      wr_r <= req_write;
      map_r <= req_map_sel;
      addr_r <= req_addr;
      wdata_r <= req_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ma_r <= '0;
    end else if (take) begin
      ma_r <= req_addr[`DDP_ROW_W-1:`DDP_ADDR_W];
    // Column goes out a cycle ahead of the column strobe
    end else if (state_r == DDP_ROW && cnt_done) begin
      ma_r <= addr_r[`DDP_ADDR_W-1:0];
    end
  end

  wire in_ras = (state_nxt == DDP_ROW) || (state_nxt == DDP_COL)
    || (state_nxt == DDP_CAS);
  wire in_cas = (state_nxt == DDP_CAS);
  wire [1:0] next_pair = take ? pair_of(req_map_sel) : pair;
  wire wr_next = take ? req_write : wr_r;
  // Write window: column setup plus the column strobe
  wire wr_window = wr_next && (state_nxt == DDP_COL || in_cas);
  wire [1:0] ras_n_nxt = in_ras ? ~next_pair : 2'h3;
  wire [1:0] cas_n_nxt = in_cas ? ~next_pair : 2'h3;
  wire [1:0] oe_n_nxt = (in_cas && !wr_next) ? ~next_pair : 2'h3;
  wire [`DDP_MAPS-1:0] we_n_nxt = wr_window ? ~map_r : 4'hf;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ras_n_r <= 2'h3;
    end else begin
      ras_n_r <= ras_n_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cas_n_r <= 2'h3;
    end else begin
      cas_n_r <= cas_n_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      oe_n_r <= 2'h3;
    end else begin
      oe_n_r <= oe_n_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      we_n_r <= 4'hf;
    end else begin
      we_n_r <= we_n_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= wr_window;
    end
  end

  assign dram_mux_address = ma_r;
  assign row_strobe_maps_low_pair_n = ras_n_r[0];
  assign row_strobe_maps_high_pair_n = ras_n_r[1];
  assign col_strobe_maps_low_pair_n = cas_n_r[0];
  assign col_strobe_maps_high_pair_n = cas_n_r[1];
  assign out_enable_maps_low_pair_n = oe_n_r[0];
  assign out_enable_maps_high_pair_n = oe_n_r[1];
  assign write_strobe_map_zero_n = we_n_r[0];
  assign write_strobe_map_one_n = we_n_r[1];
  assign write_strobe_map_two_n = we_n_r[2];
  assign write_strobe_map_three_n = we_n_r[3];
  assign display_mem_data_out = wdata_r;
  assign display_mem_data_oe_n = ~drive_r;

  // Last precharge cycle of a read hands the word over
  wire rd_last = (state_r == DDP_PRE) && cnt_done && !wr_r;

  // read data sampled through three stages
  always_ff @(posedge mclk) begin
    rd_s1_r <= display_mem_data_in;
    rd_s2_r <= rd_s1_r;
    rd_s3_r <= rd_s2_r;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_valid_r <= rd_last;
      if (rd_last) begin
        rd_data_r <= rd_s3_r;
      end
    end
  end
endmodule

/* verilog/ddp_defs.svh */
`ifndef DDP_DEFS_SVH
`define DDP_DEFS_SVH

// Pin and request widths
`define DDP_ADDR_W 9
`define DDP_DATA_W 16
`define DDP_ROW_W 18
`define DDP_MAPS 4

// Strap capture: cycles held after reset release before the sample
`define DDP_STRAP_SETTLE 8'h04

// Strobe phase lengths in mclk cycles
`define DDP_T_ROW 4'h2
`define DDP_T_CAS 4'h2
`define DDP_T_PRE 4'h2

`endif

/* verilog/ddp_pkg.sv */
package ddp_pkg;
  typedef enum logic [5:0] {
    DDP_IDLE = 6'b000001,
    DDP_ROW = 6'b000010,
    DDP_COL = 6'b000100,
    DDP_CAS = 6'b001000,
    DDP_PRE = 6'b010000,
    DDP_STRAP = 6'b100000
  } ddp_state_e;
endpackage

/* verilog/ddp_strap_cap.sv */
`timescale 1ns/100ps
`include "ddp_defs.svh"

// Samples the configuration straps on the data pins after reset.
module ddp_strap_cap
  import ddp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pin levels
  input wire logic [`DDP_DATA_W-1:0] pin_in,
  // Captured straps
  output logic [`DDP_DATA_W-1:0] strap_r,
  output logic strap_valid_r
);
  logic [7:0] settle_r;
  logic [`DDP_DATA_W-1:0] s1_r, s2_r, s3_r;
  wire settle_done = (settle_r == `DDP_STRAP_SETTLE);
  wire agree = (s2_r == s3_r);

  always_ff @(posedge mclk) begin
    s1_r <= pin_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      settle_r <= 8'h00;
    end else if (!settle_done) begin
      settle_r <= settle_r + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strap_r <= '0;
      strap_valid_r <= 1'b0;
    end else if (settle_done && agree && !strap_valid_r) begin
      strap_r <= s3_r;
      strap_valid_r <= 1'b1;
    end
  end
endmodule

/* dv/ddp_dram_model.sv */
`timescale 1ns/100ps

// Display DRAM maps, one word store per map pair.
module ddp_dram_model #(
  parameter logic [15:0] STRAP = 16'ha5c3
) (
  // DRAM pins
  input logic [8:0] a,
  input logic [1:0] ras_n,
  input logic [1:0] cas_n,
  input logic [1:0] oe_n,
  input logic [3:0] we_n,
  // Controller drive
  input logic [15:0] wd,
  input logic wd_oe_n,
  // Resolved bus
  output logic [15:0] dq
);
  logic [15:0] mem [2**19];
  logic [8:0] row [2];
  for (genvar p = 0; p < 2; p++) begin : g_pair
    // row latch; address leaves the same edge as the strobe
    always @(negedge ras_n[p]) begin
      #1;
      row[p] = a;
    end
    always @(negedge cas_n[p])
      if (we_n[2*p+1:2*p] != 2'b11) mem[{1'(p), row[p], a}] = wd;
  end
  always @* begin
    dq = STRAP;
    if (!wd_oe_n) dq = wd;
    else if (!oe_n[0] && !cas_n[0]) dq = mem[{1'b0, row[0], a}];
    else if (!oe_n[1] && !cas_n[1]) dq = mem[{1'b1, row[1], a}];
  end
endmodule

/* dv/ddp_dram_port_checker.sv */
`timescale 1ns/100ps

module ddp_port_checker (
  input logic mclk,
  input logic rst_n,
  input logic req_valid,
  input logic req_ready,
  input logic req_write,
  input logic [3:0] req_map_sel,
  input logic [17:0] req_addr,
  input logic [8:0] dram_mux_address,
  input logic row_strobe_maps_low_pair_n,
  input logic row_strobe_maps_high_pair_n,
  input logic col_strobe_maps_low_pair_n,
  input logic write_strobe_map_two_n,
  input logic out_enable_maps_high_pair_n,
  input logic display_mem_data_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire tk = req_valid && req_ready;
  wire rd = tk && !req_write;
  AST_ADDR: assert property (
    tk |=> dram_mux_address == $past(req_addr[17:9])
    ##2 dram_mux_address == $past(req_addr[8:0], 3)) else $error("addr");
  AST_RAS: assert property (
    tk && req_map_sel[0] |=> !row_strobe_maps_low_pair_n [*2])
    else $error("ras");
  AST_RASH: assert property (
    tk && req_map_sel[3:2] == 2'b00 |=> row_strobe_maps_high_pair_n [*6])
    else $error("rash");
  AST_CAS: assert property (
    tk && req_map_sel[1] |-> ##4 !col_strobe_maps_low_pair_n [*2])
    else $error("cas");
  AST_WE: assert property (
    tk && req_write && req_map_sel[2] |-> ##4 !write_strobe_map_two_n)
    else $error("we");
  AST_RDQ: assert property (
    rd |=> (write_strobe_map_two_n && display_mem_data_oe_n) [*7])
    else $error("rdq");
  AST_OE: assert property (
    rd && req_map_sel[3] |-> ##4 !out_enable_maps_high_pair_n)
    else $error("oe");
  AST_REL: assert property (
    $rose(rst_n) |-> display_mem_data_oe_n) else $error("rel");
endmodule

bind ddp_dram_port ddp_port_checker ddp_port_checker_inst (
  .mclk(mclk),
  .rst_n(rst_n),
  .req_valid(req_valid),
  .req_ready(req_ready),
  .req_write(req_write),
  .req_map_sel(req_map_sel),
  .req_addr(req_addr),
  .dram_mux_address(dram_mux_address),
  .row_strobe_maps_low_pair_n(row_strobe_maps_low_pair_n),
  .row_strobe_maps_high_pair_n(row_strobe_maps_high_pair_n),
  .col_strobe_maps_low_pair_n(col_strobe_maps_low_pair_n),
  .write_strobe_map_two_n(write_strobe_map_two_n),
  .out_enable_maps_high_pair_n(out_enable_maps_high_pair_n),
  .display_mem_data_oe_n(display_mem_data_oe_n)
);

/* dv/ddp_dram_port_test.sv */
`timescale 1ns/100ps

module ddp_dram_port_test;
  localparam logic [15:0] STRAP = 16'ha5c3;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [3:0] req_map_sel = 4'h0;
  logic [17:0] req_addr = 18'h00000;
  logic [15:0] req_wdata = 16'h0000;
  logic [15:0] rd_data_r, strap_cfg, dq, wd;
  logic req_ready, rd_valid_r, strap_valid, wd_oe_n;
  logic [8:0] a;
  wire [3:0] we_n;
  wire [1:0] ras_n, cas_n, oe_n;
  int error_cnt = 0;
  int n_tests = 0;
  initial forever #2.5 mclk = ~mclk;
  ddp_dram_model #(.STRAP(STRAP)) ddp_dram_model_inst (
    .a(a),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .wd(wd),
    .wd_oe_n(wd_oe_n),
    .dq(dq));
  ddp_dram_port ddp_dram_port_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req_write(req_write),
    .req_map_sel(req_map_sel),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .rd_valid_r(rd_valid_r),
    .rd_data_r(rd_data_r),
    .strap_cfg(strap_cfg),
    .strap_valid(strap_valid),
    .dram_mux_address(a),
    .row_strobe_maps_low_pair_n(ras_n[0]),
    .row_strobe_maps_high_pair_n(ras_n[1]),
    .col_strobe_maps_low_pair_n(cas_n[0]),
    .col_strobe_maps_high_pair_n(cas_n[1]),
    .write_strobe_map_zero_n(we_n[0]),
    .write_strobe_map_one_n(we_n[1]),
    .write_strobe_map_two_n(we_n[2]),
    .write_strobe_map_three_n(we_n[3]),
    .out_enable_maps_low_pair_n(oe_n[0]),
    .out_enable_maps_high_pair_n(oe_n[1]),
    .display_mem_data_in(dq),
    .display_mem_data_out(wd),
    .display_mem_data_oe_n(wd_oe_n));

  task automatic chk(input string s, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [3:0] s,
      input logic [17:0] ad, input logic [15:0] d);
    req_valid <= 1;
    req_write <= w;
    req_map_sel <= s;
    req_addr <= ad;
    req_wdata <= d;
    do @(negedge mclk); while (req_ready !== 1'b1);
    @(posedge mclk);
    req_valid <= 0;
    if (!w) begin
      repeat (7) @(posedge mclk);
      @(negedge mclk);
      chk("rd_valid", 1, rd_valid_r);
      chk("rd_data", d, rd_data_r);
      @(negedge mclk);
      chk("rd_valid_end", 0, rd_valid_r);
    end
    @(posedge mclk);
  endtask

  task automatic t_reset;
    @(posedge mclk);
    rst_n <= 0;
    repeat (20) @(posedge mclk);
    chk("bus_oe_n", 1, wd_oe_n);
    chk("ras_n", 3, ras_n);
    rst_n <= 1;
    repeat (20) @(posedge mclk);
    chk("strap", STRAP, strap_cfg);
    chk("strap_ok", 1, strap_valid);
  endtask

  task automatic t_maps;
    logic [3:0] s [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc};
    for (int i = 0; i < 6; i++) begin
      xfer(1, s[i], 18'(18'h3ffff - i), 16'(16'h8001 << i));
      xfer(0, s[i], 18'(18'h3ffff - i), 16'(16'h8001 << i));
    end
  endtask

  // Words written before a mid-run reset still read back
  task automatic t_keep;
    xfer(0, 4'h3, 18'h3fffb, 16'h0010);
    xfer(0, 4'hc, 18'h3fffa, 16'h0020);
  endtask

  task automatic final_report;
    $display("errors %0d tests %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    t_reset;
    t_maps;
    t_reset;
    t_keep;
    final_report;
  end

  initial begin
    #10000;
    error_cnt++;
    final_report;
  end
endmodule
